//--- verilog/fbpam_pkg.sv
// Shared constants for the fieldbus parameter address map block.
// Assumes byte addressing on the register bus, one 32-bit word per register.
package fbpam_pkg;
	// Register byte offsets
	localparam logic [5:0] OFF_MAP_SEL = 6'h00;
	localparam logic [5:0] OFF_WORD_ORDER = 6'h04;
	localparam logic [5:0] OFF_APPLY = 6'h08;
	localparam logic [5:0] OFF_TABLE_REV = 6'h0C;
	localparam logic [5:0] OFF_KIND = 6'h10;
	localparam logic [5:0] OFF_FILE_REV = 6'h14;
	localparam logic [5:0] OFF_WEB_RSV = 6'h18;
	localparam logic [5:0] OFF_STATUS = 6'h1C;

	// Status register field positions
	localparam int ST_MODE_LSB = 32'h0;
	localparam int ST_ORDER = 32'h2;
	localparam int ST_BUSY = 32'h3;
	localparam int ST_RUN = 32'h4;

	// Reset values
	localparam logic [1:0] RST_MAP_SEL = 2'h0;
	localparam logic RST_ORDER = 1'h1;
	localparam logic [15:0] RST_WEB_RSV = 16'h0000;

	// Word order encodings
	localparam logic ORDER_HI_FIRST = 1'h1;
	localparam logic ORDER_LO_FIRST = 1'h0;

	// Mapping arithmetic
	localparam logic [15:0] M0_16_MUL = 16'h0064;
	localparam logic [15:0] M0_32_BASE = 16'h4E20;
	localparam logic [15:0] M0_32_MUL = 16'h00C8;
	localparam logic [15:0] M0_MAX = 16'h0063;
	localparam logic [7:0] M3_IDX_LIM = 8'h80;

	// Half-word write enables and exception code
	localparam logic [1:0] HALF_HI = 2'h2;
	localparam logic [1:0] HALF_LO = 2'h1;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

	typedef enum logic [1:0] {
		FBPAM_MODE0 = 2'b00,
		FBPAM_MODE1 = 2'b01,
		FBPAM_MODE2 = 2'b10,
		FBPAM_MODE3 = 2'b11
	} fbpam_mode_t;
endpackage

//--- verilog/fbpam_decode.sv
// Register number to group/index decoder, one cycle latency.
// Assumes start is a one-cycle pulse and inputs hold during that cycle.
`timescale 1ns/1ps
module fbpam_decode (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic start,
	input wire fbpam_pkg::fbpam_mode_t mode,
	input wire logic [15:0] reg_num,
	output logic done,
	output logic legal,
	output logic [7:0] group,
	output logic [7:0] index,
	output logic wide,
	output logic second
);
	typedef struct packed {
		logic done;
		logic legal;
		logic [7:0] group;
		logic [7:0] index;
		logic wide;
		logic second;
	} fbpam_dec_t;

	fbpam_dec_t st_q;
	fbpam_dec_t st_d;
	logic [15:0] q;
	logic [15:0] r;
	logic [15:0] a;

	always_comb begin
		q = 16'h0000;
		r = 16'h0000;
		a = 16'h0000;
		st_d = st_q;
		st_d.done = start;
		if (start) begin
			st_d.wide = 1'b0;
			st_d.second = 1'b0;
			case (mode)
			fbpam_pkg::FBPAM_MODE0: begin
				if (reg_num < fbpam_pkg::M0_32_BASE) begin
					q = reg_num / fbpam_pkg::M0_16_MUL; // [R5]
					r = reg_num % fbpam_pkg::M0_16_MUL;
				end else begin
					a = reg_num - fbpam_pkg::M0_32_BASE; // [R6]
					q = a / fbpam_pkg::M0_32_MUL;
					r = (a % fbpam_pkg::M0_32_MUL) >> 1;
					st_d.second = a[0];
					st_d.wide = 1'b1;
				end
				st_d.group = q[7:0];
				st_d.index = r[7:0];
				st_d.legal = q != 16'h0000 && q <= fbpam_pkg::M0_MAX &&
					r != 16'h0000; // [R16]
			end
			fbpam_pkg::FBPAM_MODE1: begin
				st_d.group = reg_num[15:8]; // [R7]
				st_d.index = reg_num[7:0];
				st_d.legal = reg_num[15:8] != 8'h00 &&
					reg_num[7:0] != 8'h00;
			end
			fbpam_pkg::FBPAM_MODE2: begin
				st_d.group = {1'b0, reg_num[15:9]}; // [R8]
				st_d.index = reg_num[8:1];
				st_d.second = reg_num[0];
				st_d.wide = 1'b1;
				st_d.legal = reg_num[15:9] != 7'h00 &&
					reg_num[8:1] != 8'h00;
			end
			default: begin
				st_d.group = reg_num[15:8]; // [R9]
				st_d.index = {1'b0, reg_num[7:1]};
				st_d.second = reg_num[0];
				st_d.wide = 1'b1;
				st_d.legal = reg_num[15:8] != 8'h00 &&
					reg_num[7:1] != 7'h00;
			end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done = st_q.done;
	assign legal = st_q.legal;
	assign group = st_q.group;
	assign index = st_q.index;
	assign wide = st_q.wide;
	assign second = st_q.second;

	dec_m1_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R7]
		done && legal && $past(mode) == fbpam_pkg::FBPAM_MODE1
		|-> {group, index} == $past(reg_num) && !wide)
		else $error("mode 1 decode wrong");
	dec_m2_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R8]
		done && legal && $past(mode) == fbpam_pkg::FBPAM_MODE2
		|-> {group[6:0], index, second} == $past(reg_num) && wide &&
		!group[7])
		else $error("mode 2 decode wrong");
	dec_m3_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R9]
		done && legal && $past(mode) == fbpam_pkg::FBPAM_MODE3
		|-> {group, index[6:0], second} == $past(reg_num) &&
		index < fbpam_pkg::M3_IDX_LIM)
		else $error("mode 3 decode wrong");
	dec_m0s_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R5]
		done && legal && !wide && $past(mode) == fbpam_pkg::FBPAM_MODE0
		|-> 16'(group) * fbpam_pkg::M0_16_MUL + 16'(index) ==
		$past(reg_num))
		else $error("mode 0 16-bit decode wrong");
	dec_m0w_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R6]
		done && legal && wide && $past(mode) == fbpam_pkg::FBPAM_MODE0
		|-> fbpam_pkg::M0_32_BASE + 16'(group) * fbpam_pkg::M0_32_MUL +
		16'({index, 1'b0}) + 16'(second) == $past(reg_num))
		else $error("mode 0 32-bit decode wrong");
endmodule

//--- verilog/fbpam_top.sv
// Fieldbus parameter address map: register file, request translation.
// Assumes Modbus request and parameter store logic share clk_sys;
// drive_running comes from another domain and is synchronised.
// Operation
// R1 - Word order 1: high word of a 32-bit value in first register.
// R2 - Word order 0: low word of a 32-bit value in first register.
// R3 - Each 16-bit register goes out high byte first, then low byte.
// R4 - Mapping mode 0 to 3 selects decoding; mode 0 after reset.
// R5 - Mode 0 16-bit: register = 100 * group + index, 1 to 99.
// R6 - Mode 0 32-bit: register = 20000 + 200 * group + 2 * index.
// R7 - Mode 1: register = 256 * group + index; no 32-bit access.
// R8 - Mode 2 32-bit: 512 * group + 2 * index, groups to 127.
// R9 - Mode 3 32-bit: 256 * group + 2 * index, indexes below 128.
// R10 - Writing apply 1 applies changed settings, then reads 0 again.
// R11 - Apply refused while the drive runs; software should not try.
// R12 - Reserved web settings have no effect on the block.
// R13 - Read-only table revision reported.
// R14 - Read-only drive kind code reported; writes leave it alone.
// R15 - Read-only mapping file revision reported, decimal number.
// R16 - Undecodable register gets illegal-address answer, no access.
`timescale 1ns/1ps
module fbpam_top (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic mb_req_valid,
	output logic mb_req_ready,
	input wire logic [15:0] mb_reg,
	input wire logic mb_write,
	input wire logic [15:0] mb_wdata,
	output logic mb_rsp_valid,
	output logic [7:0] mb_rsp_byte,
	output logic mb_rsp_last,
	output logic mb_rsp_illegal,
	output logic par_req,
	output logic par_write,
	output logic [7:0] par_group,
	output logic [7:0] par_index,
	output logic par_wide,
	output logic [1:0] par_half_en,
	output logic [31:0] par_wdata,
	input wire logic par_ack,
	input wire logic [31:0] par_rdata,
	output logic cfg_apply_req,
	input wire logic cfg_apply_done,
	input wire logic drive_running,
	input wire logic [15:0] table_rev_in,
	input wire logic [15:0] drive_kind_in,
	input wire logic [15:0] file_rev_in
);
	typedef enum logic [2:0] {
		FBPAM_IDLE = 3'b000,
		FBPAM_DECODE = 3'b001,
		FBPAM_PARAM = 3'b010,
		FBPAM_SEND_LO = 3'b011
	} fbpam_state_t;

	typedef struct packed {
		logic [1:0] map_sel;
		logic order_pend;
		fbpam_pkg::fbpam_mode_t mode_act;
		logic order_act;
		logic apply;
		logic apply_req;
		logic [15:0] web_rsv;
		logic wait_r;
		logic [31:0] rdata;
		logic run_s1;
		logic run_s2;
		fbpam_state_t state;
		logic req_ready;
		logic dec_start;
		logic [15:0] reg_num;
		logic write;
		logic [15:0] wdata;
		logic hi;
		logic [15:0] word;
		logic rsp_valid;
		logic [7:0] rsp_byte;
		logic rsp_last;
		logic rsp_illegal;
		logic par_req;
		logic par_write;
		logic [7:0] par_group;
		logic [7:0] par_index;
		logic par_wide;
		logic [1:0] par_half_en;
		logic [31:0] par_wdata;
	} fbpam_top_t;

	fbpam_top_t st_q;
	fbpam_top_t st_d;
	logic dec_done;
	logic dec_legal;
	logic [7:0] dec_group;
	logic [7:0] dec_index;
	logic dec_wide;
	logic dec_second;
	logic bus_req;
	logic hi_sel;
	logic [15:0] rd_word;

	function automatic logic hit(input logic [5:0] addr,
		input logic [5:0] off);
		hit = addr[5:2] == off[5:2];
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8],
			be[0] ? wd[7:0] : old[7:0]};
	endfunction

	fbpam_decode u_decode (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.start(st_q.dec_start),
		.mode(st_q.mode_act),
		.reg_num(st_q.reg_num),
		.done(dec_done),
		.legal(dec_legal),
		.group(dec_group),
		.index(dec_index),
		.wide(dec_wide),
		.second(dec_second)
	);

	assign bus_req = avs_read | avs_write;
	// First register holds the high word only in high-first order
	assign hi_sel = st_q.order_act ? !dec_second : dec_second; // [R1] [R2]
	assign rd_word = st_q.par_wide && st_q.hi ? par_rdata[31:16] :
		par_rdata[15:0];

	always_comb begin
		st_d = st_q;
		st_d.run_s1 = drive_running;
		st_d.run_s2 = st_q.run_s1;

		// Bus slave: one wait cycle, answer stands for one cycle
		st_d.wait_r = !(bus_req && st_q.wait_r);
		if (bus_req && st_q.wait_r && avs_write) begin
			if (hit(avs_address, fbpam_pkg::OFF_MAP_SEL)) begin
				if (avs_byteenable[0]) begin
					st_d.map_sel = avs_writedata[1:0]; // [R4]
				end
			end else if (hit(avs_address, fbpam_pkg::OFF_WORD_ORDER)) begin
				if (avs_byteenable[0]) begin
					st_d.order_pend = avs_writedata[0];
				end
			end else if (hit(avs_address, fbpam_pkg::OFF_APPLY)) begin
				// Running drive or apply in progress: write dropped
				if (avs_byteenable[0] && avs_writedata[15:0] == 16'h0001 &&
					!st_q.run_s2 && !st_q.apply) begin // [R11]
					st_d.apply = 1'b1; // [R10]
					st_d.apply_req = 1'b1;
				end
			end else if (hit(avs_address, fbpam_pkg::OFF_WEB_RSV)) begin
				// Stored for readback only, steers nothing
				st_d.web_rsv = merge16(st_q.web_rsv, avs_writedata,
					avs_byteenable); // [R12]
			end
		end
		if (bus_req && st_q.wait_r && avs_read) begin
			st_d.rdata = 32'h0000_0000;
			if (hit(avs_address, fbpam_pkg::OFF_MAP_SEL)) begin
				st_d.rdata[1:0] = st_q.map_sel;
			end else if (hit(avs_address, fbpam_pkg::OFF_WORD_ORDER)) begin
				st_d.rdata[0] = st_q.order_pend;
			end else if (hit(avs_address, fbpam_pkg::OFF_APPLY)) begin
				st_d.rdata[0] = st_q.apply;
			end else if (hit(avs_address, fbpam_pkg::OFF_TABLE_REV)) begin
				st_d.rdata[15:0] = table_rev_in; // [R13]
			end else if (hit(avs_address, fbpam_pkg::OFF_KIND)) begin
				st_d.rdata[15:0] = drive_kind_in; // [R14]
			end else if (hit(avs_address, fbpam_pkg::OFF_FILE_REV)) begin
				st_d.rdata[15:0] = file_rev_in; // [R15]
			end else if (hit(avs_address, fbpam_pkg::OFF_WEB_RSV)) begin
				st_d.rdata[15:0] = st_q.web_rsv;
			end else if (hit(avs_address, fbpam_pkg::OFF_STATUS)) begin
				st_d.rdata[fbpam_pkg::ST_MODE_LSB +: 2] = st_q.mode_act;
				st_d.rdata[fbpam_pkg::ST_ORDER] = st_q.order_act;
				st_d.rdata[fbpam_pkg::ST_BUSY] = st_q.apply;
				st_d.rdata[fbpam_pkg::ST_RUN] = st_q.run_s2;
			end
		end

		// Settings take effect only when applied
		if (st_q.apply_req && cfg_apply_done) begin
			st_d.mode_act = fbpam_pkg::fbpam_mode_t'(st_q.map_sel); // [R4]
			st_d.order_act = st_q.order_pend;
			st_d.apply_req = 1'b0;
			st_d.apply = 1'b0; // [R10]
		end

		// Modbus request path
		st_d.dec_start = 1'b0;
		st_d.rsp_valid = 1'b0;
		st_d.rsp_last = 1'b0;
		st_d.rsp_illegal = 1'b0;
		case (st_q.state)
		FBPAM_IDLE: begin
			if (mb_req_valid && st_q.req_ready) begin
				st_d.req_ready = 1'b0;
				st_d.reg_num = mb_reg;
				st_d.write = mb_write;
				st_d.wdata = mb_wdata;
				st_d.dec_start = 1'b1;
				st_d.state = FBPAM_DECODE;
			end
		end
		FBPAM_DECODE: begin
			if (dec_done) begin
				if (!dec_legal) begin
					// No parameter access for a bad number
					st_d.rsp_valid = 1'b1; // [R16]
					st_d.rsp_illegal = 1'b1;
					st_d.rsp_last = 1'b1;
					st_d.rsp_byte = fbpam_pkg::EXC_ILLEGAL_ADDR;
					st_d.req_ready = 1'b1;
					st_d.state = FBPAM_IDLE;
				end else begin
					st_d.hi = dec_wide && hi_sel; // [R1] [R2]
					st_d.par_req = 1'b1;
					st_d.par_write = st_q.write;
					st_d.par_group = dec_group;
					st_d.par_index = dec_index;
					st_d.par_wide = dec_wide;
					st_d.par_wdata = {st_q.wdata, st_q.wdata};
					st_d.par_half_en = dec_wide && hi_sel ?
						fbpam_pkg::HALF_HI : fbpam_pkg::HALF_LO;
					st_d.state = FBPAM_PARAM;
				end
			end
		end
		FBPAM_PARAM: begin
			if (par_ack) begin
				st_d.par_req = 1'b0;
				st_d.word = st_q.par_write ? st_q.wdata : rd_word;
				st_d.rsp_valid = 1'b1;
				st_d.rsp_byte = st_q.par_write ? st_q.wdata[15:8] :
					rd_word[15:8]; // [R3]
				st_d.state = FBPAM_SEND_LO;
			end
		end
		FBPAM_SEND_LO: begin
			st_d.rsp_valid = 1'b1;
			st_d.rsp_byte = st_q.word[7:0]; // [R3]
			st_d.rsp_last = 1'b1;
			st_d.req_ready = 1'b1;
			st_d.state = FBPAM_IDLE;
		end
		default: begin
			st_d.state = FBPAM_IDLE;
			st_d.req_ready = 1'b1;
		end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
			st_q.map_sel <= fbpam_pkg::RST_MAP_SEL;
			st_q.mode_act <= fbpam_pkg::FBPAM_MODE0; // [R4]
			st_q.order_pend <= fbpam_pkg::RST_ORDER;
			st_q.order_act <= fbpam_pkg::RST_ORDER;
			st_q.web_rsv <= fbpam_pkg::RST_WEB_RSV;
			st_q.wait_r <= 1'b1;
			st_q.req_ready <= 1'b1;
			st_q.state <= FBPAM_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign avs_readdata = st_q.rdata;
	assign avs_waitrequest = st_q.wait_r;
	assign mb_req_ready = st_q.req_ready;
	assign mb_rsp_valid = st_q.rsp_valid;
	assign mb_rsp_byte = st_q.rsp_byte;
	assign mb_rsp_last = st_q.rsp_last;
	assign mb_rsp_illegal = st_q.rsp_illegal;
	assign par_req = st_q.par_req;
	assign par_write = st_q.par_write;
	assign par_group = st_q.par_group;
	assign par_index = st_q.par_index;
	assign par_wide = st_q.par_wide;
	assign par_half_en = st_q.par_half_en;
	assign par_wdata = st_q.par_wdata;
	assign cfg_apply_req = st_q.apply_req;

	sequence hi_beat_s;
		mb_rsp_valid && !mb_rsp_last && !mb_rsp_illegal;
	endsequence
	sequence lo_beat_s;
		mb_rsp_valid && mb_rsp_last && !mb_rsp_illegal;
	endsequence

	byte_pair_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R3]
		hi_beat_s |=> lo_beat_s ##1 !mb_rsp_valid)
		else $error("response bytes not paired high then low");
	hi_first_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R1]
		st_q.state == FBPAM_PARAM && par_ack && !par_write && par_wide &&
		st_q.order_act && st_q.par_half_en == fbpam_pkg::HALF_HI
		|=> mb_rsp_byte == $past(par_rdata[31:24]))
		else $error("high word not first in high-first order");
	lo_first_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R2]
		st_q.state == FBPAM_DECODE && dec_done && dec_legal && dec_wide &&
		!dec_second && !st_q.order_act
		|=> par_half_en == fbpam_pkg::HALF_LO)
		else $error("low word not first in low-first order");
	ill_nopar_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R16]
		st_q.state == FBPAM_DECODE && dec_done && !dec_legal
		|=> mb_rsp_illegal && mb_rsp_byte == fbpam_pkg::EXC_ILLEGAL_ADDR &&
		!par_req ##1 !par_req)
		else $error("illegal number reached the parameter store");
	mode_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R4]
		$changed(st_q.mode_act) |-> $past(cfg_apply_done && cfg_apply_req))
		else $error("mapping mode changed without apply");
	apply_ret_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R10]
		cfg_apply_req && cfg_apply_done |=> !st_q.apply && !cfg_apply_req)
		else $error("apply control did not return to zero");
	run_block_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R11]
		avs_write && avs_waitrequest && st_q.run_s2 && !st_q.apply &&
		hit(avs_address, fbpam_pkg::OFF_APPLY) |=> !cfg_apply_req)
		else $error("apply accepted while drive running");
	kind_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R14]
		avs_read && avs_waitrequest && hit(avs_address, fbpam_pkg::OFF_KIND)
		|=> !avs_waitrequest && avs_readdata[15:0] == $past(drive_kind_in))
		else $error("drive kind code readback wrong");
endmodule

//--- test/fbpam_store_model.sv
// Parameter store model: answers par_req with a one-cycle par_ack.
// Assumes par_req stays up until the ack edge and drops after it.
`timescale 1ns/1ps
module fbpam_store_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic par_req,
	input wire logic [7:0] par_group,
	input wire logic [7:0] par_index,
	output logic par_ack,
	output logic [31:0] par_rdata
);
	logic [2:0] wait_q;
	logic [31:0] val_q;
	// Data outside the ack cycle is inverted so stale values cannot pass
	assign par_rdata = par_ack ? val_q : ~val_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wait_q <= 3'h0;
			par_ack <= 1'b0;
			val_q <= 32'h0;
		end else if (par_ack) begin
			par_ack <= 1'b0;
			wait_q <= 3'h0;
		end else if (par_req && wait_q >= (slow ? 3'h4 : 3'h0)) begin
			par_ack <= 1'b1;
			val_q <= {par_group, par_index, ~par_group, ~par_index};
		end else if (par_req) begin
			wait_q <= wait_q + 3'h1;
		end
	end
endmodule

//--- test/fbpam_top_test.sv
// Self-checking bench for the parameter address map.
// Assumes the store model above and one 100 MHz clock.
`timescale 1ns/1ps
module fbpam_top_test;
	logic clk_sys = 1'b0, arst_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, par_wdata, par_rdata;
	logic [3:0] avs_byteenable = 4'hF;
	logic mb_req_valid = 1'b0, mb_write = 1'b0, mb_req_ready;
	logic [15:0] mb_reg = 16'h0, mb_wdata = 16'h0;
	logic mb_rsp_valid, mb_rsp_last, mb_rsp_illegal, par_req, par_write;
	logic [7:0] mb_rsp_byte, par_group, par_index, pg, pi;
	logic par_wide, par_ack, cfg_apply_req, pw, pwr, slow = 1'b0;
	logic [1:0] par_half_en, ph;
	logic [31:0] pwd;
	logic cfg_apply_done = 1'b0, drive_running = 1'b0;
	logic [15:0] table_rev_in = 16'h0123, drive_kind_in = 16'h0A5C;
	logic [15:0] file_rev_in = 16'h0042;
	int fail_count = 0, checks_done = 0;

	fbpam_top u_fbpam_top (.clk_sys(clk_sys), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mb_req_valid(mb_req_valid),
		.mb_req_ready(mb_req_ready), .mb_reg(mb_reg), .mb_write(mb_write),
		.mb_wdata(mb_wdata), .mb_rsp_valid(mb_rsp_valid),
		.mb_rsp_byte(mb_rsp_byte), .mb_rsp_last(mb_rsp_last),
		.mb_rsp_illegal(mb_rsp_illegal), .par_req(par_req),
		.par_write(par_write), .par_group(par_group),
		.par_index(par_index), .par_wide(par_wide),
		.par_half_en(par_half_en), .par_wdata(par_wdata),
		.par_ack(par_ack), .par_rdata(par_rdata),
		.cfg_apply_req(cfg_apply_req), .cfg_apply_done(cfg_apply_done),
		.drive_running(drive_running), .table_rev_in(table_rev_in),
		.drive_kind_in(drive_kind_in), .file_rev_in(file_rev_in));

	fbpam_store_model u_fbpam_store_model (.clk_sys(clk_sys),
		.arst_n(arst_n), .slow(slow), .par_req(par_req),
		.par_group(par_group), .par_index(par_index),
		.par_ack(par_ack), .par_rdata(par_rdata));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; waits for waitrequest low, then one idle edge
	task automatic avs(input logic w, input logic [5:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk_sys);
		// No cycle count assumed; a hang is left to the watchdog
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	// One Modbus request; records the store access and the reply bytes
	task automatic mb(input logic [15:0] r, input logic w,
		input logic [15:0] wd, output logic [15:0] rsp, output logic ill);
		rsp = 16'h0;
		ill = 1'b0;
		mb_reg <= r;
		mb_write <= w;
		mb_wdata <= wd;
		mb_req_valid <= 1'b1;
		@(posedge clk_sys);
		while (mb_req_ready !== 1'b1)
			@(posedge clk_sys);
		mb_req_valid <= 1'b0;
		// A missing last byte is caught by the watchdog
		forever begin
			@(posedge clk_sys);
			if (par_req === 1'b1) begin
				pg = par_group;
				pi = par_index;
				pw = par_wide;
				pwr = par_write;
				pwd = par_wdata;
				ph = par_half_en;
			end
			if (mb_rsp_valid === 1'b1) begin
				rsp = {rsp[7:0], mb_rsp_byte};
				ill = mb_rsp_illegal;
				if (mb_rsp_last === 1'b1)
					break;
			end
		end
		@(posedge clk_sys);
	endtask

	// Read access; hi selects which half of the stored word comes back
	task automatic par_rd(input logic [15:0] r, input logic [7:0] g,
		input logic [7:0] i, input logic wide, input logic hi);
		logic [15:0] rsp;
		logic ill;
		logic [31:0] v;
		v = {g, i, ~g, ~i};
		pg = 8'h0;
		pi = 8'h0;
		mb(r, 1'b0, 16'h0, rsp, ill);
		check({15'h0, ill, pg, pi}, {16'h0, g, i});
		check(32'(pw), 32'(wide));
		check(32'(rsp), 32'(hi ? v[31:16] : v[15:0]));
	endtask

	task automatic illegal(input logic [15:0] r);
		logic [15:0] rsp;
		logic ill;
		mb(r, 1'b0, 16'h0, rsp, ill);
		check({23'h0, ill, rsp[7:0]}, {23'h1, fbpam_pkg::EXC_ILLEGAL_ADDR});
	endtask

	task automatic set_mode(input logic [1:0] m, input logic o);
		logic [31:0] d;
		avs(1'b1, fbpam_pkg::OFF_MAP_SEL, 32'(m), d);
		avs(1'b1, fbpam_pkg::OFF_WORD_ORDER, 32'(o), d);
		avs(1'b1, fbpam_pkg::OFF_APPLY, 32'h1, d);
		avs(1'b0, fbpam_pkg::OFF_APPLY, 32'h0, d);
		check(d, 32'h1);
		check(32'(cfg_apply_req), 32'h1);
		cfg_apply_done <= 1'b1;
		@(posedge clk_sys);
		cfg_apply_done <= 1'b0;
		repeat (2) @(posedge clk_sys);
		avs(1'b0, fbpam_pkg::OFF_APPLY, 32'h0, d);
		check(d, 32'h0);
		avs(1'b0, fbpam_pkg::OFF_STATUS, 32'h0, d);
		check(32'(d[2:0]), 32'({o, m}));
	endtask

	task automatic t_regs();
		logic [31:0] d;
		avs(1'b0, fbpam_pkg::OFF_MAP_SEL, 32'h0, d);
		check(d, 32'h0);
		avs(1'b0, fbpam_pkg::OFF_STATUS, 32'h0, d);
		check(d, 32'h4);
		avs(1'b0, 6'h20, 32'h0, d);
		check(d, 32'h0);
		avs(1'b1, fbpam_pkg::OFF_KIND, 32'hFFFF, d);
		avs(1'b0, fbpam_pkg::OFF_KIND, 32'h0, d);
		check(d, 32'h0A5C);
		avs(1'b0, fbpam_pkg::OFF_TABLE_REV, 32'h0, d);
		check(d, 32'h0123);
		avs(1'b0, fbpam_pkg::OFF_FILE_REV, 32'h0, d);
		check(d, 32'h0042);
		// Web reserved settings must not disturb decoding
		avs(1'b1, fbpam_pkg::OFF_WEB_RSV, 32'hFFFF, d);
		par_rd(16'd5107, 8'd51, 8'd7, 1'b0, 1'b0);
	endtask

	task automatic t_mode0();
		logic [15:0] rsp;
		logic ill;
		par_rd(16'd101, 8'd1, 8'd1, 1'b0, 1'b0);
		par_rd(16'd30214, 8'd51, 8'd7, 1'b1, 1'b1);
		par_rd(16'd30215, 8'd51, 8'd7, 1'b1, 1'b0);
		mb(16'd5107, 1'b1, 16'h1234, rsp, ill);
		check(32'({ph, pwr, rsp}), 32'({fbpam_pkg::HALF_LO, 1'b1, 16'h1234}));
		check(pwd, 32'h1234_1234);
		illegal(16'd100);
		illegal(16'd10050);
	endtask

	task automatic t_running();
		logic [31:0] d;
		drive_running <= 1'b1;
		repeat (4) @(posedge clk_sys);
		avs(1'b1, fbpam_pkg::OFF_APPLY, 32'h1, d);
		avs(1'b0, fbpam_pkg::OFF_APPLY, 32'h0, d);
		check({d[30:0], cfg_apply_req}, 32'h0);
		avs(1'b0, fbpam_pkg::OFF_STATUS, 32'h0, d);
		check(32'(d[4]), 32'h1);
		drive_running <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic t_modes();
		logic [15:0] rsp;
		logic ill;
		set_mode(2'h1, 1'b0);
		par_rd(16'h3301, 8'd51, 8'd1, 1'b0, 1'b0);
		par_rd(16'hFFFF, 8'd255, 8'd255, 1'b0, 1'b0);
		illegal(16'h3300);
		set_mode(2'h2, 1'b0);
		slow <= 1'b1;
		par_rd(16'd26114, 8'd51, 8'd1, 1'b1, 1'b0);
		par_rd(16'd26115, 8'd51, 8'd1, 1'b1, 1'b1);
		// Second register in low-first order carries the high half
		mb(16'd26115, 1'b1, 16'hBEEF, rsp, ill);
		check(32'({ph, pw, rsp}), 32'({fbpam_pkg::HALF_HI, 1'b1, 16'hBEEF}));
		set_mode(2'h3, 1'b1);
		par_rd(16'd13058, 8'd51, 8'd1, 1'b1, 1'b1);
		par_rd(16'd13059, 8'd51, 8'd1, 1'b1, 1'b0);
		slow <= 1'b0;
		set_mode(2'h0, 1'b1);
		par_rd(16'd9999, 8'd99, 8'd99, 1'b0, 1'b0);
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_mode0();
		t_running();
		t_modes();
		summarize();
	end

	// Whole run needs a few hundred cycles; the 20000-cycle limit is a wide margin
	initial begin
		#200000;
		fail_count++;
		summarize();
	end
endmodule
